/* File: rtl/pwtc_consts.vh */
// Register map, field positions and reset values of the wakeup tick counter
`ifndef PWTC_CONSTS_VH
`define PWTC_CONSTS_VH

// Register offsets on the plain register port
`define PWTC_OFS_STATUS_CONTROL 2'h0
`define PWTC_OFS_TICK_COUNT     2'h1
`define PWTC_OFS_MATCH_LIMIT    2'h2

// Field positions in the status/control register
`define PWTC_FLAG_BIT           7
`define PWTC_SRC_HI             6
`define PWTC_SRC_LO             5
`define PWTC_IRQEN_BIT          4
`define PWTC_DIV_HI             3
`define PWTC_DIV_LO             0

// Source select encodings
`define PWTC_SRC_LPO            2'h0
`define PWTC_SRC_EXT            2'h1

// Reset values
`define PWTC_RST_SRC            2'h0
`define PWTC_RST_DIV            4'h0
`define PWTC_RST_LIMIT          8'h00
`define PWTC_RST_COUNT          8'h00
`define PWTC_RST_PRESC          18'h00000

// Divider select value that turns the prescaler off
`define PWTC_DIV_OFF            4'h0

// Prescaler terminal counts (ratio minus one), source low bit 0
`define PWTC_TC_LO_1            18'h00007
`define PWTC_TC_LO_2            18'h0001f
`define PWTC_TC_LO_3            18'h0003f
`define PWTC_TC_LO_4            18'h0007f
`define PWTC_TC_LO_5            18'h000ff
`define PWTC_TC_LO_6            18'h001ff
`define PWTC_TC_LO_7            18'h003ff
`define PWTC_TC_LO_8            18'h00000
`define PWTC_TC_LO_9            18'h00001
`define PWTC_TC_LO_A            18'h00003
`define PWTC_TC_LO_B            18'h00009
`define PWTC_TC_LO_C            18'h0000f
`define PWTC_TC_LO_D            18'h00063
`define PWTC_TC_LO_E            18'h001f3
`define PWTC_TC_LO_F            18'h003e7

// Prescaler terminal counts (ratio minus one), source low bit 1
`define PWTC_TC_HI_1            18'h003ff
`define PWTC_TC_HI_2            18'h007ff
`define PWTC_TC_HI_3            18'h00fff
`define PWTC_TC_HI_4            18'h01fff
`define PWTC_TC_HI_5            18'h03fff
`define PWTC_TC_HI_6            18'h07fff
`define PWTC_TC_HI_7            18'h0ffff
`define PWTC_TC_HI_8            18'h003e7
`define PWTC_TC_HI_9            18'h007cf
`define PWTC_TC_HI_A            18'h01387
`define PWTC_TC_HI_B            18'h0270f
`define PWTC_TC_HI_C            18'h04e1f
`define PWTC_TC_HI_D            18'h0c34f
`define PWTC_TC_HI_E            18'h1869f
`define PWTC_TC_HI_F            18'h30d3f

`endif

/* File: rtl/pwtc_periodic_wakeup_tick_counter.v */
// Periodic wakeup tick counter with prescaler, match limit and flag
`timescale 1ns/1ps
`include "pwtc_consts.vh"

// What this block does
// - 8-bit up-counter compared against 8-bit match limit
// - Match raises periodic interrupt, software enable
// - Keeps counting in wait mode, can wake
// - Keeps counting in light stop, in deep stop on the oscillator only, wakes
// - Oscillator in both stops, references light only
// - No clock source, no wakeup
// - Debug freezes counting, resume from held value
// - Flag bit 7, write one clears, reset clears
// - Source select bits 6-5, reset to 00
// - New source value clears prescaler and counter
// - Enable bit 4 gates request, reset clears
// - Divider bits 3-0, new value clears counters
// - Low bit 0 divide table, zero is off
// - Low bit 1 divide table, zero is off
// - Three registers, no off-chip pins
// - Increment per prescaler period, wrap on match
// - Limit zero flags every prescaler output
// - Limit write clears counters, resets to zero
// - Count register read-only, writes ignored
module pwtc_periodic_wakeup_tick_counter (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire [1:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdData,
    input  wire       lowPowerOscClock,
    input  wire       externalRefClock,
    input  wire       internalRefClock,
    input  wire       deepStopMode,
    input  wire       debugActive,
    output wire       matchIrq,
    output wire       wakeupReq
);

    // Configuration and counting state
    reg  [1:0]  srcSel_q;
    reg  [3:0]  divSel_q;
    reg         irqEn_q;
    reg         flag_q;
    reg  [7:0]  limit_q;
    reg  [7:0]  count_q;
    reg  [17:0] presc_q;
    // Combinational selections
    reg  [7:0]  rdData_d;
    reg         srcRise;
    // Source edges, decode and counting strobes
    wire [2:0]  srcLevel;
    wire [2:0]  srcRiseAll;
    wire        srcAvail;
    wire        srcEdge;
    wire        prescOn;
    wire        prescTick;
    wire        wrStatus;
    wire        wrLimit;
    wire        srcChange;
    wire        divChange;
    wire        cfgChange;
    wire        clrCounters;
    wire        matchHit;
    wire        flagSet;
    wire        flagClr;
    wire [17:0] prescLimit;

    // Last prescaler count (ratio minus one) for a divider setting
    // Zero selects nothing here; the off case is gated by prescOn
    function [17:0] divLimit;
        input       lowBit;
        input [3:0] sel;
        begin
            divLimit = 18'h00000;
            if (!lowBit) begin
                case (sel)
                    // Binary steps
                    4'h1: begin
                        divLimit = `PWTC_TC_LO_1; // Divide by 8
                    end
                    4'h2: begin
                        divLimit = `PWTC_TC_LO_2; // Divide by 32
                    end
                    4'h3: begin
                        divLimit = `PWTC_TC_LO_3; // Divide by 64
                    end
                    4'h4: begin
                        divLimit = `PWTC_TC_LO_4; // Divide by 128
                    end
                    4'h5: begin
                        divLimit = `PWTC_TC_LO_5; // Divide by 256
                    end
                    4'h6: begin
                        divLimit = `PWTC_TC_LO_6; // Divide by 512
                    end
                    4'h7: begin
                        divLimit = `PWTC_TC_LO_7; // Divide by 1024
                    end
                    // Decimal steps
                    4'h8: begin
                        divLimit = `PWTC_TC_LO_8; // Divide by 1
                    end
                    4'h9: begin
                        divLimit = `PWTC_TC_LO_9; // Divide by 2
                    end
                    4'ha: begin
                        divLimit = `PWTC_TC_LO_A; // Divide by 4
                    end
                    4'hb: begin
                        divLimit = `PWTC_TC_LO_B; // Divide by 10
                    end
                    4'hc: begin
                        divLimit = `PWTC_TC_LO_C; // Divide by 16
                    end
                    4'hd: begin
                        divLimit = `PWTC_TC_LO_D; // Divide by 100
                    end
                    4'he: begin
                        divLimit = `PWTC_TC_LO_E; // Divide by 500
                    end
                    4'hf: begin
                        divLimit = `PWTC_TC_LO_F; // Divide by 1000
                    end
                    default: begin
                        divLimit = 18'h00000;
                    end
                endcase
            end else begin
                case (sel)
                    // Binary steps
                    4'h1: begin
                        divLimit = `PWTC_TC_HI_1; // Divide by 1024
                    end
                    4'h2: begin
                        divLimit = `PWTC_TC_HI_2; // Divide by 2048
                    end
                    4'h3: begin
                        divLimit = `PWTC_TC_HI_3; // Divide by 4096
                    end
                    4'h4: begin
                        divLimit = `PWTC_TC_HI_4; // Divide by 8192
                    end
                    4'h5: begin
                        divLimit = `PWTC_TC_HI_5; // Divide by 16384
                    end
                    4'h6: begin
                        divLimit = `PWTC_TC_HI_6; // Divide by 32768
                    end
                    4'h7: begin
                        divLimit = `PWTC_TC_HI_7; // Divide by 65536
                    end
                    // Decimal steps
                    4'h8: begin
                        divLimit = `PWTC_TC_HI_8; // Divide by 1000
                    end
                    4'h9: begin
                        divLimit = `PWTC_TC_HI_9; // Divide by 2000
                    end
                    4'ha: begin
                        divLimit = `PWTC_TC_HI_A; // Divide by 5000
                    end
                    4'hb: begin
                        divLimit = `PWTC_TC_HI_B; // Divide by 10000
                    end
                    4'hc: begin
                        divLimit = `PWTC_TC_HI_C; // Divide by 20000
                    end
                    4'hd: begin
                        divLimit = `PWTC_TC_HI_D; // Divide by 50000
                    end
                    4'he: begin
                        divLimit = `PWTC_TC_HI_E; // Divide by 100000
                    end
                    4'hf: begin
                        divLimit = `PWTC_TC_HI_F; // Divide by 200000
                    end
                    default: begin
                        divLimit = 18'h00000;
                    end
                endcase
            end
        end
    endfunction

    // Per-source edge history, so a source switch sees no stale level
    assign srcLevel = {internalRefClock, externalRefClock, lowPowerOscClock};
    genvar s;
    generate
        for (s = 0; s < 3; s = s + 1) begin : gSrcEdge
            reg prev_q;
            // Sampled level of this source; idle level is low
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    prev_q <= 1'b0;
                end else begin
                    prev_q <= srcLevel[s];
                end
            end
            assign srcRiseAll[s] = srcLevel[s] & ~prev_q;
        end
    endgenerate

    // Source mux on the select field; 1x both pick the internal clock
    always @* begin
        srcRise = 1'b0;
        case (srcSel_q)
            `PWTC_SRC_LPO: begin
                srcRise = srcRiseAll[0];
            end
            `PWTC_SRC_EXT: begin
                srcRise = srcRiseAll[1];
            end
            default: begin
                srcRise = srcRiseAll[2];
            end
        endcase
    end

    // References vanish in deep stop, the oscillator stays
    assign srcAvail = (srcSel_q == `PWTC_SRC_LPO) | ~deepStopMode;

    // Counting edge, frozen while debug is active
    assign srcEdge  = srcRise & srcAvail & ~debugActive;

    // Bus decode; a changed source or divider field, or any limit write, clears the counters
    assign wrStatus    = regWr & (regAddr == `PWTC_OFS_STATUS_CONTROL);
    assign wrLimit     = regWr & (regAddr == `PWTC_OFS_MATCH_LIMIT);
    assign srcChange   = regWrData[`PWTC_SRC_HI:`PWTC_SRC_LO] != srcSel_q;
    assign divChange   = regWrData[`PWTC_DIV_HI:`PWTC_DIV_LO] != divSel_q;
    assign cfgChange   = wrStatus & (srcChange | divChange);
    assign clrCounters = cfgChange | wrLimit;

    // Prescaler output pulse; none while divider is off
    assign prescOn    = divSel_q != `PWTC_DIV_OFF;
    assign prescLimit = divLimit(srcSel_q[0], divSel_q);
    assign prescTick  = srcEdge & prescOn & (presc_q == prescLimit);
    assign matchHit   = prescTick & (count_q == limit_q);

    // Flag events; a match in a counter-clearing cycle is dropped
    // because the count it belongs to is being thrown away
    assign flagSet = matchHit & ~clrCounters;
    assign flagClr = wrStatus & regWrData[`PWTC_FLAG_BIT];

    // Request while flag and enable are set; wakes from wait and stops
    assign matchIrq  = flag_q & irqEn_q;
    assign wakeupReq = matchIrq;

    // Control fields: source select, divider and enable
    always @(posedge core_clk) begin
        if (!rst_n) begin
            srcSel_q <= `PWTC_RST_SRC;
            divSel_q <= `PWTC_RST_DIV;
            irqEn_q  <= 1'b0;
        end else begin
            if (wrStatus) begin
                srcSel_q <= regWrData[`PWTC_SRC_HI:`PWTC_SRC_LO];
                divSel_q <= regWrData[`PWTC_DIV_HI:`PWTC_DIV_LO];
                irqEn_q  <= regWrData[`PWTC_IRQEN_BIT];
            end
        end
    end

    // Match limit; any write also clears the counters
    always @(posedge core_clk) begin
        if (!rst_n) begin
            limit_q <= `PWTC_RST_LIMIT;
        end else if (wrLimit) begin
            limit_q <= regWrData;
        end
    end

    // Match flag: set wins over a clear in the same cycle
    always @(posedge core_clk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (flagSet) begin
            flag_q <= 1'b1;
        end else if (flagClr) begin
            flag_q <= 1'b0;
        end
    end

    // Prescaler and tick counter
    always @(posedge core_clk) begin
        if (!rst_n) begin
            presc_q <= `PWTC_RST_PRESC;
            count_q <= `PWTC_RST_COUNT;
        end else if (clrCounters) begin
            presc_q <= `PWTC_RST_PRESC;
            count_q <= `PWTC_RST_COUNT;
        end else if (srcEdge && prescOn) begin
            if (prescTick) begin
                presc_q <= `PWTC_RST_PRESC;
                if (matchHit) begin
                    count_q <= `PWTC_RST_COUNT;
                end else begin
                    count_q <= count_q + 8'h01;
                end
            end else begin
                presc_q <= presc_q + 18'h00001;
            end
        end
    end

    // Read mux; the unmapped offset reads zero
    always @* begin
        rdData_d = 8'h00;
        case (regAddr)
            `PWTC_OFS_STATUS_CONTROL: begin
                rdData_d = {flag_q, srcSel_q, irqEn_q, divSel_q};
            end
            `PWTC_OFS_TICK_COUNT: begin
                rdData_d = count_q;
            end
            `PWTC_OFS_MATCH_LIMIT: begin
                rdData_d = limit_q;
            end
            default: begin
                rdData_d = 8'h00;
            end
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge core_clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            regRdData <= rdData_d;
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule

/* File: tb/pwtc_props.sv */
// Port assertions for the wakeup tick counter
`timescale 1ns/1ps
module pwtc_props (
    input wire       core_clk,
    input wire       rst_n,
    input wire [1:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWr,
    input wire       regRd,
    input wire [7:0] regRdData,
    input wire       debugActive,
    input wire       matchIrq,
    input wire       wakeupReq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Limit write while counting is frozen
    sequence limWr;
        regWr && regAddr == 2'h2 && debugActive;
    endsequence
    // Request outputs, bus read data and reset
    wake_same_a: assert property (wakeupReq == matchIrq)
        else $error("wakeup differs from irq");
    idle_rd_a: assert property (!regRd |=> !regRdData)
        else $error("read data outside read cycle");
    hole_rd_a: assert property (regRd && regAddr == 2'h3 |=> !regRdData)
        else $error("unmapped read not zero");
    rd_irq_a: assert property (regRd && !regAddr
        |=> (regRdData[7] & regRdData[4]) == $past(matchIrq))
        else $error("irq disagrees with flag and enable");
    en_off_a: assert property (regWr && !regAddr && !regWrData[4]
        |=> !matchIrq) else $error("irq with enable cleared");
    dbg_hold_a: assert property (debugActive && !regWr
        |=> !$rose(matchIrq)) else $error("flag set while frozen");
    rst_clr_a: assert property (disable iff (1'b0)
        !rst_n |=> !regRdData && !matchIrq) else $error("reset not cleared");
    lim_clr_a: assert property (limWr ##1 (regRd && regAddr == 2'h1
        && debugActive) |=> !regRdData) else $error("limit write kept count");
endmodule
bind pwtc_periodic_wakeup_tick_counter pwtc_props pwtc_props_i (
    .core_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .debugActive, .matchIrq, .wakeupReq);

/* File: tb/test_periodic_wakeup_tick_counter.sv */
// Self-checking bench for the wakeup tick counter
`timescale 1ns/1ps
module test_periodic_wakeup_tick_counter;
    logic       core_clk = 0, rst_n = 0, regWr = 0, regRd = 0;
    logic       stop = 0, dbg = 0;
    logic [1:0] regAddr = 0;
    logic [7:0] regWrData = 0;
    logic [2:0] srcClk = 0;
    wire  [7:0] regRdData;
    wire        matchIrq;
    wire        wakeReq;
    int         failures = 0, num_checks = 0, cycles = 0;
    pwtc_periodic_wakeup_tick_counter pwtc_periodic_wakeup_tick_counter_i (
        .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .lowPowerOscClock(srcClk[0]),
        .externalRefClock(srcClk[1]), .internalRefClock(srcClk[2]),
        .deepStopMode(stop), .debugActive(dbg), .matchIrq(matchIrq),
        .wakeupReq(wakeReq));
    // Clock and hang guard
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic chk(input logic [9:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One-cycle register write; strobe is dropped by the next task
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        regRd <= 0;
        regWr <= 1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
    endtask
    // Read; data and irq judged in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] d, input logic q);
        regWr <= 0;
        regRd <= 1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 0;
        @(negedge core_clk);
        chk({wakeReq, matchIrq, regRdData}, {q, q, d}, "wake irq data");
        @(posedge core_clk);
    endtask
    // Pulses on one source clock, two cycles high and two low
    task automatic pulse(input int i, input int n);
        regWr <= 0;
        regRd <= 0;
        repeat (n) begin
            srcClk[i] <= 1;
            repeat (2) @(posedge core_clk);
            srcClk[i] <= 0;
            repeat (2) @(posedge core_clk);
        end
    endtask
    task automatic tReset();
        rd(0, 0, 0); rd(1, 0, 0); rd(2, 0, 0); rd(3, 0, 0);
        $display("reset values done");
    endtask
    task automatic tCount();
        wr(2, 2); wr(0, 8'h08); pulse(0, 2); rd(1, 2, 0);
        pulse(0, 1); rd(0, 8'h88, 0); rd(1, 0, 0);
        wr(0, 8'h18); rd(0, 8'h98, 1); wr(1, 8'h55); rd(1, 0, 1);
        wr(0, 8'h98); rd(0, 8'h18, 0);
        wr(2, 0); pulse(0, 1); rd(0, 8'h98, 1);
        $display("count and flag done");
    endtask
    task automatic tDiv();
        wr(2, 5); wr(0, 8'h98); pulse(0, 1); rd(1, 1, 0);
        wr(0, 8'h19); rd(1, 0, 0); pulse(0, 3); rd(1, 1, 0);
        wr(0, 8'h10); pulse(0, 2); rd(1, 0, 0);
        wr(0, 8'h18); pulse(0, 1); dbg <= 1; pulse(0, 2); rd(1, 1, 0);
        dbg <= 0; pulse(0, 1); rd(1, 2, 0);
        dbg <= 1; wr(2, 5); rd(1, 0, 0); dbg <= 0;
        $display("divider and debug done");
    endtask
    task automatic tSrc();
        pulse(0, 1); wr(0, 8'h28); rd(1, 0, 0);
        pulse(1, 999); rd(1, 0, 0); pulse(1, 1); rd(1, 1, 0);
        stop <= 1; pulse(1, 1000); rd(1, 1, 0);
        wr(0, 8'h48); pulse(2, 1); rd(1, 0, 0);
        stop <= 0; pulse(2, 1); rd(1, 1, 0);
        stop <= 1; wr(0, 8'h08); pulse(0, 1); rd(1, 1, 0); stop <= 0;
        $display("source select done");
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        tReset();
        tCount();
        tDiv();
        tSrc();
        print_verdict();
    end
endmodule
